// File: tmr8_defs.vh
`ifndef TMR8_DEFS_VH
`define TMR8_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TMR8_ADDR_CTRL 3'h0
`define TMR8_ADDR_COUNT 3'h1
`define TMR8_ADDR_CMP 3'h2
`define TMR8_ADDR_FLAGS 3'h3
`define TMR8_ADDR_PINDIR 3'h4

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TMR8_CTRL_FORCE 7
`define TMR8_CTRL_WAVE_LO 6
`define TMR8_CTRL_COM_HI 5
`define TMR8_CTRL_COM_LO 4
`define TMR8_CTRL_WAVE_HI 3
`define TMR8_CTRL_CS_HI 2
`define TMR8_CTRL_CS_LO 0

// ----------------------------------------
// Flag bits
// ----------------------------------------
`define TMR8_FLAG_OVF 0
`define TMR8_FLAG_MATCH 1

// ----------------------------------------
// Waveform modes
// ----------------------------------------
`define TMR8_WAVE_NORMAL 2'h0
`define TMR8_WAVE_PHASE 2'h1
`define TMR8_WAVE_CTC 2'h2
`define TMR8_WAVE_FAST 2'h3

// ----------------------------------------
// Output modes
// ----------------------------------------
`define TMR8_COM_OFF 2'h0
`define TMR8_COM_TOGGLE 2'h1
`define TMR8_COM_CLEAR 2'h2
`define TMR8_COM_SET 2'h3

// ----------------------------------------
// Clock select codes
// ----------------------------------------
`define TMR8_CS_STOP 3'h0
`define TMR8_CS_DIV1 3'h1
`define TMR8_CS_DIV8 3'h2
`define TMR8_CS_DIV64 3'h3
`define TMR8_CS_DIV256 3'h4
`define TMR8_CS_DIV1024 3'h5

// ----------------------------------------
// Counter limits, reset values and prescaler width
// ----------------------------------------
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_CTRL_RST 8'h00
`define TMR8_PRESCALE_W 10

`endif

// File: tmr8_waveform.v
`include "tmr8_defs.vh"

module tmr8_waveform (
  input wire ref_clk,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg overflow_flag,
  output reg compare_match_flag,
  output reg compare_output,
  output reg compare_pin_out,
  output reg compare_pin_oe
);

  // ----------------------------------------
  // Software state
  // ----------------------------------------
  reg [1:0] waveform_mode_sel_r;
  reg [1:0] compare_output_mode_r;
  reg [2:0] clk_sel_r;
  reg pin_dir_r;
  reg [7:0] count_value_r;
  reg [7:0] compare_value_r;
  reg [7:0] compare_buf_r;
  reg count_up_r;
  reg block_r;
  reg [`TMR8_PRESCALE_W-1:0] prescale_r;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_ctrl = reg_wr && (reg_addr == `TMR8_ADDR_CTRL);
  wire wr_count = reg_wr && (reg_addr == `TMR8_ADDR_COUNT);
  wire wr_cmp = reg_wr && (reg_addr == `TMR8_ADDR_CMP);
  wire wr_flags = reg_wr && (reg_addr == `TMR8_ADDR_FLAGS);
  wire wr_dir = reg_wr && (reg_addr == `TMR8_ADDR_PINDIR);
  wire is_pwm = waveform_mode_sel_r[0];
  wire is_fast = (waveform_mode_sel_r == `TMR8_WAVE_FAST);
  wire is_phase = (waveform_mode_sel_r == `TMR8_WAVE_PHASE);
  wire is_ctc = (waveform_mode_sel_r == `TMR8_WAVE_CTC);
  wire at_max = (count_value_r == `TMR8_MAX);
  wire at_bottom = (count_value_r == `TMR8_BOTTOM);
  wire force_cmp = wr_ctrl && reg_wdata[`TMR8_CTRL_FORCE] && !reg_wdata[`TMR8_CTRL_WAVE_LO];

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Free running so that a new divide takes effect at once
  // One wire per divide above 1, so the decode stays a plain select
  wire end_div8 = (prescale_r[2:0] == 3'h7);
  wire end_div64 = (prescale_r[5:0] == 6'h3f);
  wire end_div256 = (prescale_r[7:0] == 8'hff);
  wire end_div1024 = (prescale_r == 10'h3ff);

  reg tick;
  always @* begin
    case (clk_sel_r)
      `TMR8_CS_DIV1: tick = 1'b1;
      `TMR8_CS_DIV8: tick = end_div8;
      `TMR8_CS_DIV64: tick = end_div64;
      `TMR8_CS_DIV256: tick = end_div256;
      `TMR8_CS_DIV1024: tick = end_div1024;
      // Reserved select codes fall to stop
      default: tick = 1'b0;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      prescale_r <= {`TMR8_PRESCALE_W{1'b0}};
    end else begin
      prescale_r <= prescale_r + 10'h001;
    end
  end

  // ----------------------------------------
  // Compare and next count
  // ----------------------------------------
  wire match = (count_value_r == compare_value_r) && !block_r;
  // Phase correct: BOTTOM counts as an up match so compare 0 stays low in clear mode
  wire phase_up = at_bottom || (count_up_r && !at_max);

  reg [7:0] count_nxt;
  reg count_up_nxt;
  always @* begin
    count_nxt = count_value_r + 8'h01;
    count_up_nxt = count_up_r;
    case (waveform_mode_sel_r)
      `TMR8_WAVE_CTC: begin
        if (count_value_r == compare_value_r) begin
          count_nxt = `TMR8_BOTTOM;
        end
      end
      `TMR8_WAVE_FAST: begin
        if (at_max) begin
          count_nxt = `TMR8_BOTTOM;
        end
      end
      `TMR8_WAVE_PHASE: begin
        if (at_max) begin
          count_up_nxt = 1'b0;
          count_nxt = `TMR8_MAX - 8'h01;
        end else if (at_bottom) begin
          count_up_nxt = 1'b1;
          count_nxt = `TMR8_BOTTOM + 8'h01;
        end else if (!count_up_r) begin
          count_nxt = count_value_r - 8'h01;
        end
      end
      default: begin
        count_nxt = count_value_r + 8'h01;
      end
    endcase
  end

  // ----------------------------------------
  // Overflow event
  // ----------------------------------------
  reg ovf_set;
  always @* begin
    case (waveform_mode_sel_r)
      `TMR8_WAVE_NORMAL: ovf_set = at_max;
      // Missed match just runs on through the wrap
      `TMR8_WAVE_CTC: ovf_set = at_max;
      `TMR8_WAVE_FAST: ovf_set = at_max;
      `TMR8_WAVE_PHASE: ovf_set = at_bottom;
      default: ovf_set = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Flag events
  // ----------------------------------------
  // Events only count on a tick, a stopped timer raises nothing
  wire ovf_evt = tick && ovf_set;
  wire match_evt = tick && match;

  // ----------------------------------------
  // Waveform output
  // ----------------------------------------
  reg oc_nxt;
  always @* begin
    oc_nxt = compare_output;
    if (!is_pwm) begin
      if (match || force_cmp) begin
        case (compare_output_mode_r)
          `TMR8_COM_TOGGLE: oc_nxt = ~compare_output;
          `TMR8_COM_CLEAR: oc_nxt = 1'b0;
          `TMR8_COM_SET: oc_nxt = 1'b1;
          default: oc_nxt = compare_output;
        endcase
      end
    end else if (is_fast) begin
      case (compare_output_mode_r)
        `TMR8_COM_TOGGLE: begin
          if (match) begin
            oc_nxt = ~compare_output;
          end
        end
        `TMR8_COM_CLEAR: begin
          // Match at MAX ignored, wrap level wins: constant output
          if (at_max) begin
            oc_nxt = 1'b1;
          end else if (match) begin
            oc_nxt = 1'b0;
          end
        end
        `TMR8_COM_SET: begin
          if (at_max) begin
            oc_nxt = 1'b0;
          end else if (match) begin
            oc_nxt = 1'b1;
          end
        end
        default: oc_nxt = compare_output;
      endcase
    end else begin
      if (match && compare_output_mode_r[1]) begin
        oc_nxt = compare_output_mode_r[0] ? phase_up : ~phase_up;
      end
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Ticks are qualifiers only, nothing runs on a derived clock
  always @(posedge ref_clk) begin
    if (rst) begin
      count_value_r <= `TMR8_BOTTOM;
    end else if (wr_count) begin
      count_value_r <= reg_wdata;
    end else if (tick) begin
      count_value_r <= count_nxt;
    end
  end

  // Direction survives a count write, so a write never flips the slope
  always @(posedge ref_clk) begin
    if (rst) begin
      count_up_r <= 1'b1;
    end else if (tick && !wr_count) begin
      count_up_r <= count_up_nxt;
    end
  end

  // ----------------------------------------
  // Match blocking
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      block_r <= 1'b0;
    end else if (wr_count) begin
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Compare buffer and active compare
  // ----------------------------------------
  // Readback shows the buffer, so software sees its own write at once
  always @(posedge ref_clk) begin
    if (rst) begin
      compare_buf_r <= 8'h00;
    end else if (wr_cmp) begin
      compare_buf_r <= reg_wdata;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      compare_value_r <= 8'h00;
    end else if (wr_cmp && !is_pwm) begin
      compare_value_r <= reg_wdata;
    end else if (is_pwm && tick && at_max) begin
      compare_value_r <= compare_buf_r;
    end
  end

  // ----------------------------------------
  // Waveform register
  // ----------------------------------------
  // Keeps its level across mode changes
  always @(posedge ref_clk) begin
    if (rst) begin
      compare_output <= 1'b0;
    end else if ((tick && !wr_count) || force_cmp) begin
      compare_output <= oc_nxt;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // Set wins over a clear in the same cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag <= 1'b1;
    end else if (wr_flags && reg_wdata[`TMR8_FLAG_OVF]) begin
      overflow_flag <= 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      compare_match_flag <= 1'b0;
    end else if (match_evt) begin
      compare_match_flag <= 1'b1;
    end else if (wr_flags && reg_wdata[`TMR8_FLAG_MATCH]) begin
      compare_match_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Output mode is not buffered, a change acts on the next event
  always @(posedge ref_clk) begin
    if (rst) begin
      waveform_mode_sel_r <= `TMR8_WAVE_NORMAL;
      compare_output_mode_r <= `TMR8_COM_OFF;
      clk_sel_r <= `TMR8_CS_STOP;
    end else if (wr_ctrl) begin
      waveform_mode_sel_r <= {reg_wdata[`TMR8_CTRL_WAVE_HI], reg_wdata[`TMR8_CTRL_WAVE_LO]};
      compare_output_mode_r <= reg_wdata[`TMR8_CTRL_COM_HI:`TMR8_CTRL_COM_LO];
      clk_sel_r <= reg_wdata[`TMR8_CTRL_CS_HI:`TMR8_CTRL_CS_LO];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      pin_dir_r <= 1'b0;
    end else if (wr_dir) begin
      pin_dir_r <= reg_wdata[0];
    end
  end

  // ----------------------------------------
  // Pin
  // ----------------------------------------
  // One cycle behind the internal output, same as the enable
  wire oc_nxt_pin = compare_output;

  always @(posedge ref_clk) begin
    if (rst) begin
      compare_pin_out <= 1'b0;
      compare_pin_oe <= 1'b0;
    end else begin
      compare_pin_out <= oc_nxt_pin;
      compare_pin_oe <= pin_dir_r && (compare_output_mode_r != `TMR8_COM_OFF);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Idle cycles read zero, so a stale value never looks like an answer
  reg [7:0] rdata_nxt;
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `TMR8_ADDR_CTRL: rdata_nxt = {1'b0, waveform_mode_sel_r[0], compare_output_mode_r,
                                      waveform_mode_sel_r[1], clk_sel_r};
        `TMR8_ADDR_COUNT: rdata_nxt = count_value_r;
        `TMR8_ADDR_CMP: rdata_nxt = compare_buf_r;
        `TMR8_ADDR_FLAGS: rdata_nxt = {6'h00, compare_match_flag, overflow_flag};
        `TMR8_ADDR_PINDIR: rdata_nxt = {7'h00, pin_dir_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule

// File: tmr8_waveform_props.sv
`include "tmr8_defs.vh"
module tmr8_props (
  input wire ref_clk,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire overflow_flag,
  input wire compare_match_flag,
  input wire compare_output,
  input wire compare_pin_out,
  input wire compare_pin_oe
);
  logic [6:0] ctrl_r;
  logic [7:0] cmp_r;
  logic dir_r;
  wire stop_h = ctrl_r[2:0] == 3'h0 || ctrl_r[2:0] > 3'h5;
  wire oe_h = dir_r && ctrl_r[5:4] != 2'h0;
  wire fl_wr = reg_wr && reg_addr == `TMR8_ADDR_FLAGS;
  // ----------------------------------------
  // Shadow copies, so reads can be judged
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= 7'h00;
      cmp_r <= 8'h00;
      dir_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `TMR8_ADDR_CTRL) ctrl_r <= reg_wdata[6:0];
      if (reg_addr == `TMR8_ADDR_CMP) cmp_r <= reg_wdata;
      if (reg_addr == `TMR8_ADDR_PINDIR) dir_r <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_CTRL_READ: assert property (
    reg_rd && reg_addr == `TMR8_ADDR_CTRL |=> reg_rdata == {1'b0, $past(ctrl_r)})
    else $error("control readback wrong");
  AST_UNMAPPED: assert property (
    reg_rd && reg_addr > `TMR8_ADDR_PINDIR |=> reg_rdata == 8'h00) else $error("unmapped read");
  AST_CMP_READ: assert property (
    reg_rd && reg_addr == `TMR8_ADDR_CMP |=> reg_rdata == $past(cmp_r))
    else $error("compare readback wrong");
  AST_OVF_HOLD: assert property (
    overflow_flag && !(fl_wr && reg_wdata[0]) |=> overflow_flag) else $error("overflow lost");
  AST_MATCH_HOLD: assert property (
    compare_match_flag && !(fl_wr && reg_wdata[1]) |=> compare_match_flag)
    else $error("match flag lost");
  AST_STOP_OVF: assert property (
    $past(stop_h) |-> !$rose(overflow_flag)) else $error("overflow while stopped");
  AST_STOP_MATCH: assert property (
    $past(stop_h) |-> !$rose(compare_match_flag)) else $error("match while stopped");
  AST_PIN_OE: assert property (
    compare_pin_oe == $past(oe_h)) else $error("pin enable wrong");
  AST_PIN_LEVEL: assert property (
    compare_pin_out == $past(compare_output)) else $error("pin level wrong");
endmodule

// File: tb.sv
`include "tmr8_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, v, rv;
  wire [7:0] reg_rdata;
  wire overflow_flag, compare_match_flag, compare_output, compare_pin_out, compare_pin_oe;
  int error_cnt, samples_checked, seed, n, i;
  int divs [5] = '{1, 8, 64, 256, 1024};
  tmr8_waveform u_dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .overflow_flag(overflow_flag),
    .compare_match_flag(compare_match_flag), .compare_output(compare_output),
    .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  function automatic int exp_hi(input int ph, input int d);
    return ph == 1 ? 2 * d : d + 1;
  endfunction
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Bounded so a dead output cannot hang the run
  task wait_for(input logic ovf, input logic lv, output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (((ovf ? overflow_flag : compare_output) !== lv) && c < 3000);
  endtask
  // Compare written while stopped in normal mode, so it is live at once
  task start(input logic [7:0] c, input logic [7:0] cv, input logic [7:0] ct);
    wr(`TMR8_ADDR_CTRL, 8'h00);
    wr(`TMR8_ADDR_CMP, c);
    wr(`TMR8_ADDR_COUNT, cv);
    wr(`TMR8_ADDR_FLAGS, 8'h03);
    wr(`TMR8_ADDR_CTRL, ct);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    complete_run;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h5a56f483;
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 3'h0, 8'h00};
    {error_cnt, samples_checked} = 64'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      rd(i[2:0], rv);
      chk("reset_read", 16'h0000, {8'h00, rv});
    end
    $display("reset test done");
    for (i = 0; i < 5; i++) begin
      v = i == 0 ? 8'hc0 | 8'($random(seed)) : 8'hff;
      start(8'h00, v, {5'h00, 3'(i + 1)});
      wait_for(1'b1, 1'b1, n);
      if (i == 0) chk("ovf_cycles", 16'h0100 - 16'(v), 16'(n));
      else chk("ovf_in_prescale", 16'h0001, {15'h0, n <= divs[i]});
    end
    wr(`TMR8_ADDR_CTRL, 8'h00);
    wr(`TMR8_ADDR_COUNT, v ^ 8'h5a);
    rd(`TMR8_ADDR_COUNT, rv);
    chk("count_write", {8'h00, v ^ 8'h5a}, {8'h00, rv});
    start(8'h05, 8'h05, 8'h01);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("blocked_match", 16'h0000, {15'h0, compare_match_flag});
    $display("normal test done");
    v = 8'h03 + 8'($random(seed) & 15);
    start(v, 8'h00, 8'h19);
    wr(`TMR8_ADDR_PINDIR, 8'h01);
    wait_for(1'b0, 1'b1, n);
    wait_for(1'b0, 1'b0, n);
    chk("ctc_half_period", 16'(v) + 16'h1, 16'(n));
    chk("ctc_flags", 16'h0002, {14'h0, compare_match_flag, overflow_flag});
    chk("ctc_pin_oe", 16'h0001, {15'h0, compare_pin_oe});
    wr(`TMR8_ADDR_PINDIR, 8'h00);
    $display("ctc test done");
    for (i = 0; i < 3; i++) begin
      v = i == 2 ? 8'h00 : 8'h10 + 8'($random(seed) & 8'h7f);
      start(v, 8'h00, i == 1 ? 8'h61 : 8'h69);
      wait_for(1'b0, 1'b0, n);
      wait_for(1'b0, 1'b1, n);
      wait_for(1'b0, 1'b0, n);
      chk("pwm_high", 16'(exp_hi(i, v)), 16'(n));
      wait_for(1'b0, 1'b1, n);
      chk("pwm_low", 16'((i == 1 ? 510 : 256) - exp_hi(i, v)), 16'(n));
      wr(`TMR8_ADDR_FLAGS, 8'h01);
      wait_for(1'b1, 1'b1, n);
      chk("pwm_ovf", 16'h0001, {15'h0, n <= (i == 1 ? 510 : 256)});
    end
    for (i = 0; i < 2; i++) begin
      start(8'hff, 8'h00, i == 1 ? 8'h79 : 8'h69);
      repeat (300) @(posedge ref_clk);
      n = 0;
      repeat (260) begin
        @(posedge ref_clk);
        #1;
        n += compare_output !== (i == 0);
      end
      chk("fast_max_level", 16'h0000, 16'(n));
    end
    start(v, 8'h00, 8'h59);
    wait_for(1'b0, 1'b0, n);
    wait_for(1'b0, 1'b1, n);
    wait_for(1'b0, 1'b0, n);
    chk("fast_toggle", 16'h0100, 16'(n));
    $display("pwm test done");
    complete_run;
  end
endmodule
bind tmr8_waveform tmr8_props u_props (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .overflow_flag(overflow_flag),
  .compare_match_flag(compare_match_flag), .compare_output(compare_output),
  .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe)
);
